// File: design/bdm_addr_gen.sv
// Combinational address former for operand accesses.
// Assumes the mode input is one of the one-hot codes of the package.
`timescale 1ns/1ps
`include "bdm_consts.svh"

module bdm_addr_gen (
    // Operand
    input  wire bdm_pkg::bdm_mode_e      mode,
    input  wire logic [`BDM_OFS_W-1:0]   addr8,
    input  wire logic [`BDM_ADDR_W-1:0]  addr12,
    input  wire logic [`BDM_BANK_W-1:0]  bank,
    // Resolved address
    output logic      [`BDM_ADDR_W-1:0]  addr_out
);

    // Access window: low half is bank 0, high half the SPECIAL_FUNCTION_REGISTERS bank.
    function automatic logic [`BDM_ADDR_W-1:0] access_map(
        input logic [`BDM_OFS_W-1:0] ofs);
        access_map = ofs[`BDM_ACC_SPLIT_BIT] ?
                     {`BDM_ACC_HIGH_BANK, ofs} :
                     {`BDM_ACC_LOW_BANK, ofs};
    endfunction : access_map

    wire logic [`BDM_ADDR_W-1:0] banked_addr;
    wire logic [`BDM_ADDR_W-1:0] window_addr;

    // ------------------------------------------------------------------
    // Address selection
    // ------------------------------------------------------------------
    // Bank supplies the top nibble, the operand the low byte.
    assign banked_addr = {bank, addr8};
    assign window_addr = access_map(addr8);
    // Only the full move carries all twelve bits; others use 8 bits.
    assign addr_out = (mode == bdm_pkg::BDM_MODE_FULL)   ? addr12 :
                      (mode == bdm_pkg::BDM_MODE_ACCESS) ? window_addr :
                      banked_addr;

endmodule : bdm_addr_gen

// File: design/bdm_consts.svh
// Constants for the banked data memory addressing block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef BDM_CONSTS_SVH
`define BDM_CONSTS_SVH

// ----------------------------------------------------------------------
// Data space geometry
// ----------------------------------------------------------------------
`define BDM_ADDR_W        12
`define BDM_DEPTH         4096
`define BDM_BANKS         16
`define BDM_BANK_W        4
`define BDM_OFS_W         8

// ----------------------------------------------------------------------
// Access window split: low half from bank 0, high half from the SPECIAL_FUNCTION_REGISTERS bank
// ----------------------------------------------------------------------
`define BDM_ACC_LOW_BANK  4'h0
`define BDM_ACC_HIGH_BANK 4'hf
`define BDM_ACC_SPLIT_BIT 7

// ----------------------------------------------------------------------
// APB register offsets and reset values
// ----------------------------------------------------------------------
`define BDM_OFF_BANK_SEL  12'h000
`define BDM_OFF_STATUS    12'h004
`define BDM_BANK_RESET    4'h0
`define BDM_IMPL_ALL      16'hffff

`endif

// File: design/bdm_mem.sv
// Byte-wide data memory of the whole 12-bit data space.
// Assumes one access per cycle; read data are registered.
`timescale 1ns/1ps
`include "bdm_consts.svh"

module bdm_mem (
    // Clock
    input  wire logic                    pclk,
    // Access port
    input  wire logic                    we,
    input  wire logic [`BDM_ADDR_W-1:0]  addr,
    input  wire logic [7:0]              wdata,
    output logic      [7:0]              rdata_r
);

    logic [7:0] mem [0:`BDM_DEPTH-1];

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // No reset on the array so it maps onto plain RAM.
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_r <= mem[addr];
    end

endmodule : bdm_mem

// File: design/bdm_pkg.sv
// Types shared by the banked data memory addressing block.
// Assumes nothing of its surroundings.
package bdm_pkg;

    // ------------------------------------------------------------------
    // How an operand address is resolved
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BDM_MODE_BANKED = 3'b001,
        BDM_MODE_ACCESS = 3'b010,
        BDM_MODE_FULL   = 3'b100
    } bdm_mode_e;

endpackage : bdm_pkg

// File: design/bdm_top.sv
// Banked data memory addressing: bank register, address former, memory.
// Assumes an APB master on pclk and a core request port on pclk.
//
// Functional notes
// - Every data location is reached by a 12-bit address, 4096 bytes.
// - The space is 16 banks of 256 bytes; all 16 are implemented by default (BANK_IMPL).
// - A read of an unimplemented location returns zero.
// - A 256-byte access window is reached without the bank register.
// - Banked addresses take the bank register as the top 4 bits.
// - Only bank register bits 3..0 exist; bits 7..4 read zero.
// - A load-bank-literal command loads the bank register directly.
// - Unimplemented bank writes are dropped, reads zero, still answered.
// - The full-address move uses 12-bit addresses and ignores the bank.
// - All other accesses use the bank register or the access window.
`timescale 1ns/1ps
`include "bdm_consts.svh"

module bdm_top #(
    parameter logic [`BDM_BANKS-1:0] BANK_IMPL = `BDM_IMPL_ALL
) (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Core operand request
    input  wire logic                    req_valid,
    input  wire logic                    req_write,
    input  wire bdm_pkg::bdm_mode_e      req_mode,
    input  wire logic [`BDM_OFS_W-1:0]   req_addr8,
    input  wire logic [`BDM_ADDR_W-1:0]  req_addr12,
    input  wire logic [7:0]              req_wdata,
    // Core load-bank-literal command
    input  wire logic                    load_bank_literal,
    input  wire logic [7:0]              lit_data,
    // Core answer
    output logic                         rsp_valid,
    output logic      [7:0]              rsp_rdata,
    output logic      [`BDM_ADDR_W-1:0]  rsp_addr,
    output logic                         rsp_impl
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [`BDM_BANK_W-1:0]  bank_select_reg_r;
    logic [`BDM_BANK_W-1:0]  bank_select_reg_nxt;
    logic                    s1_valid_r;
    logic                    s1_write_r;
    logic                    s1_impl_r;
    logic [`BDM_ADDR_W-1:0]  s1_addr_r;
    logic [7:0]              mem_rdata;
    logic [`BDM_ADDR_W-1:0]  last_addr_r;
    logic                    pready_r;
    logic [31:0]             prdata_r;
    logic                    pslverr_r;
    logic                    rsp_valid_r;
    logic [7:0]              rsp_rdata_r;
    logic [`BDM_ADDR_W-1:0]  rsp_addr_r;
    logic                    rsp_impl_r;

    wire logic [`BDM_ADDR_W-1:0] res_addr;
    wire logic                   res_impl;
    wire logic                   mem_we;
    wire logic                   apb_access;
    wire logic                   apb_done;
    wire logic                   hit_bank;
    wire logic                   hit_status;
    wire logic                   bank_apb_we;
    wire logic [31:0]            rd_mux;

    // ------------------------------------------------------------------
    // Address formation and bank decode
    // ------------------------------------------------------------------
    bdm_addr_gen u_addr_gen (
        .mode     (req_mode),
        .addr8    (req_addr8),
        .addr12   (req_addr12),
        .bank     (bank_select_reg_r),
        .addr_out (res_addr)
    );

    // A bank is usable only if built; every bank is by default.
    assign res_impl = BANK_IMPL[res_addr[`BDM_ADDR_W-1:`BDM_OFS_W]];
    // Writes into an unbuilt bank never reach the array.
    assign mem_we = req_valid & req_write & res_impl;

    // ------------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------------
    bdm_mem u_mem (
        .pclk    (pclk),
        .we      (mem_we),
        .addr    (res_addr),
        .wdata   (req_wdata),
        .rdata_r (mem_rdata)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // One wait state so that every APB output comes from a flop.
    assign apb_access  = psel & penable & ~pready_r;
    assign apb_done    = psel & penable & pready_r;
    assign hit_bank    = (paddr == `BDM_OFF_BANK_SEL);
    assign hit_status  = (paddr == `BDM_OFF_STATUS);
    assign bank_apb_we = apb_access & pwrite & hit_bank;
    // Bits above the bank nibble always read zero.
    assign rd_mux = hit_bank   ? {28'h0000000, bank_select_reg_r} :
                    hit_status ? {20'h00000, last_addr_r} :
                    32'h00000000;

    // The core's literal load wins over a same-cycle APB write.
    assign bank_select_reg_nxt =
        load_bank_literal ? lit_data[`BDM_BANK_W-1:0] :
        bank_apb_we       ? pwdata[`BDM_BANK_W-1:0] :
        bank_select_reg_r;

    // ------------------------------------------------------------------
    // Bank select register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_reg_r <= `BDM_BANK_RESET;
        end else begin
            bank_select_reg_r <= bank_select_reg_nxt;
        end
    end

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= apb_access;
            if (apb_access) begin
                prdata_r  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_r <= ~(hit_bank | hit_status);
            end else if (apb_done) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Operand pipeline, two cycles from request to answer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_valid_r  <= 1'b0;
            s1_write_r  <= 1'b0;
            s1_impl_r   <= 1'b0;
            s1_addr_r   <= 12'h000;
            last_addr_r <= 12'h000;
        end else begin
            s1_valid_r <= req_valid;
            s1_write_r <= req_write;
            s1_impl_r  <= res_impl;
            s1_addr_r  <= res_addr;
            if (req_valid) begin
                last_addr_r <= res_addr;
            end
        end
    end

    // The answer still comes for an unbuilt bank so status flags update.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= 8'h00;
            rsp_addr_r  <= 12'h000;
            rsp_impl_r  <= 1'b0;
        end else begin
            rsp_valid_r <= s1_valid_r;
            rsp_rdata_r <= (s1_impl_r & ~s1_write_r) ? mem_rdata
                                                     : 8'h00;
            rsp_addr_r  <= s1_addr_r;
            rsp_impl_r  <= s1_impl_r;
        end
    end

    assign pready    = pready_r;
    assign prdata    = prdata_r;
    assign pslverr   = pslverr_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rsp_rdata_r;
    assign rsp_addr  = rsp_addr_r;
    assign rsp_impl  = rsp_impl_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_answer_latency: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid |-> ##2 rsp_valid_r)
        else $error("answer did not follow request by two cycles");

    a_lit_load_bank: assert property (
        @(posedge pclk) disable iff (!presetn)
        load_bank_literal |=> bank_select_reg_r == $past(lit_data[3:0]))
        else $error("literal load did not reach bank register");

    a_banked_form: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_mode == bdm_pkg::BDM_MODE_BANKED |=>
        s1_addr_r == {$past(bank_select_reg_r), $past(req_addr8)})
        else $error("banked address not formed from bank and operand");

    a_window_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_mode == bdm_pkg::BDM_MODE_ACCESS && !req_addr8[7]
        |=> s1_addr_r == {4'h0, $past(req_addr8)})
        else $error("low access window not in bank 0");

    a_window_high: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_mode == bdm_pkg::BDM_MODE_ACCESS && req_addr8[7]
        |=> s1_addr_r == {4'hf, $past(req_addr8)})
        else $error("high access window not in bank 15");

    a_full_move: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_mode == bdm_pkg::BDM_MODE_FULL |-> ##2
        rsp_addr_r == $past(req_addr12, 2))
        else $error("full move address altered");

    a_unimpl_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && !res_impl |-> ##2 rsp_valid_r && rsp_rdata_r == 8'h00)
        else $error("unimplemented read not zero");

    a_unimpl_nowrite: assert property (
        @(posedge pclk) disable iff (!presetn)
        mem_we |-> res_impl && req_valid)
        else $error("write reached an unimplemented bank");

    a_bank_upper_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        apb_access && !pwrite && hit_bank |=> prdata_r[31:4] == 28'h0000000
        && prdata_r[3:0] == $past(bank_select_reg_r))
        else $error("bank register upper bits not zero");

    // The checks below tie each answer and each bank change to its cause.
    // A stray change of the bank register would silently move every
    // banked access, so it is watched on every cycle.
    a_bank_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !load_bank_literal && !bank_apb_we |=>
        bank_select_reg_r == $past(bank_select_reg_r))
        else $error("bank register changed without a load");

    a_apb_bank_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        bank_apb_we && !load_bank_literal |=>
        bank_select_reg_r == $past(pwdata[3:0]))
        else $error("bus write did not reach bank register");

    a_apb_one_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        apb_access |=> pready_r)
        else $error("bus access not answered after one wait state");

    a_unmapped_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        apb_access && !hit_bank && !hit_status |=>
        pready_r && pslverr_r && prdata_r == 32'h00000000)
        else $error("unmapped register access not refused");

    a_write_no_data: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_write |-> ##2 rsp_valid_r && rsp_rdata_r == 8'h00)
        else $error("write answer carried data");

    a_no_stray_answer: assert property (
        @(posedge pclk) disable iff (!presetn)
        !req_valid |-> ##2 !rsp_valid_r)
        else $error("answer given without a request");

    a_full_impl: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_mode == bdm_pkg::BDM_MODE_FULL |-> ##2
        rsp_impl_r == BANK_IMPL[$past(req_addr12[11:8], 2)])
        else $error("bank presence flag wrong for full move");

    a_full_early: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_mode == bdm_pkg::BDM_MODE_FULL |=>
        s1_addr_r == $past(req_addr12))
        else $error("full move address not taken whole");

    a_low_operand: assert property (
        @(posedge pclk) disable iff (!presetn)
        req_valid && req_mode != bdm_pkg::BDM_MODE_FULL |=>
        s1_addr_r[7:0] == $past(req_addr8))
        else $error("short operand not used as low address byte");

endmodule : bdm_top

// File: verification/bdm_core_model.sv
// Model of the core execution unit that issues operand requests.
// Assumes the block answers a taken request within four clock edges.
`timescale 1ns/1ps

module bdm_core_model (
    // Clock
    input  wire logic                pclk,
    // Requests to the block
    output logic                     req_valid,
    output logic                     req_write,
    output bdm_pkg::bdm_mode_e       req_mode,
    output logic [7:0]               req_addr8,
    output logic [11:0]              req_addr12,
    output logic [7:0]               req_wdata,
    output logic                     load_bank_literal,
    output logic [7:0]               lit_data,
    // Answers from the block
    input  wire logic                rsp_valid,
    input  wire logic [7:0]          rsp_rdata,
    input  wire logic [11:0]         rsp_addr,
    input  wire logic                rsp_impl
);
    // Idle values; released address, data and literal lines show a changed pattern, never old data; req_write and req_mode keep theirs.
    initial begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_mode = bdm_pkg::BDM_MODE_BANKED;
        req_addr8 = 8'h00;
        req_addr12 = 12'h000;
        req_wdata = 8'h00;
        load_bank_literal = 1'b0;
        lit_data = 8'h00;
    end

    // Load the bank register; the upper literal bits are junk on purpose.
    task automatic load_lit(input logic [7:0] v);
        @(posedge pclk);
        load_bank_literal <= 1'b1;
        lit_data <= v;
        @(posedge pclk);
        load_bank_literal <= 1'b0;
        lit_data <= ~v;
    endtask : load_lit

    // One operand access; ok is low when no answer came in time.
    task automatic access(input logic wr, input bdm_pkg::bdm_mode_e m,
                          input logic [7:0] a8, input logic [11:0] a12,
                          input logic [7:0] wd, output logic [7:0] rd,
                          output logic [11:0] ad, output logic im,
                          output logic ok);
        int n;
        n = 0;
        @(posedge pclk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_mode <= m;
        req_addr8 <= a8;
        req_addr12 <= a12;
        req_wdata <= wd;
        @(posedge pclk);
        req_valid <= 1'b0;
        req_addr8 <= ~a8;
        req_addr12 <= ~a12;
        req_wdata <= ~wd;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 4);
        rd = rsp_rdata;
        ad = rsp_addr;
        im = rsp_impl;
        ok = (rsp_valid === 1'b1);
    endtask : access
endmodule : bdm_core_model

// File: verification/test_banked_data_memory_addressing.sv
// Self-checking bench: APB master tasks plus the core model.
// Assumes bank 14 is built as unimplemented to reach the dropped path.
`timescale 1ns/1ps

module test_banked_data_memory_addressing;
    logic               pclk, presetn, psel, penable, pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic               pready, pslverr, er;
    logic               req_valid, req_write, load_bank_literal;
    bdm_pkg::bdm_mode_e req_mode;
    logic [7:0]         req_addr8, req_wdata, lit_data, rsp_rdata;
    logic [11:0]        req_addr12, rsp_addr;
    logic               rsp_valid, rsp_impl;
    int                 mismatches, checked;

    bdm_top #(.BANK_IMPL(16'hbfff)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req_write(req_write),
        .req_mode(req_mode), .req_addr8(req_addr8),
        .req_addr12(req_addr12), .req_wdata(req_wdata),
        .load_bank_literal(load_bank_literal), .lit_data(lit_data),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_addr(rsp_addr), .rsp_impl(rsp_impl));

    bdm_core_model core_u (.pclk(pclk), .req_valid(req_valid),
        .req_write(req_write), .req_mode(req_mode),
        .req_addr8(req_addr8), .req_addr12(req_addr12),
        .req_wdata(req_wdata), .load_bank_literal(load_bank_literal),
        .lit_data(lit_data), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_addr(rsp_addr),
        .rsp_impl(rsp_impl));

    // 100 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // APB transfer; the bench timeout is the only end to a stuck wait.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Core access with expected address, data and bank presence.
    task automatic xfer(input logic wr, input bdm_pkg::bdm_mode_e m,
                        input logic [7:0] a8, input logic [11:0] a12,
                        input logic [7:0] wd, input logic [11:0] ea,
                        input logic [7:0] ed);
        logic [7:0] d;
        logic [11:0] ad;
        logic im, ok;
        core_u.access(wr, m, a8, a12, wd, d, ad, im, ok);
        chk("rsp_valid", {31'h0, ok}, 32'h1);
        chk("rsp_addr", {20'h0, ad}, {20'h0, ea});
        chk("rsp_impl", {31'h0, im}, {31'h0, ea[11:8] != 4'he});
        chk("rsp_rdata", {24'h0, d}, {24'h0, ed});
    endtask : xfer

    // Watchdog at 5000 cycles, well beyond the few hundred cycles the tests need.
    initial begin
        #50000;
        mismatches++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        mismatches = 0;
        checked = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("bank reset", rd, 32'h0);
        apb(1'b1, 12'h000, 32'hffffffff);
        apb(1'b0, 12'h000, 32'h0);
        chk("bank upper", rd, 32'h0000000f);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test registers done");
        // Every bank: load, write, read back; bank 14 drops the write.
        for (int b = 0; b < 16; b++) begin
            core_u.load_lit({4'ha, b[3:0]});
            xfer(1'b1, bdm_pkg::BDM_MODE_BANKED, 8'h35, 12'h0,
                 8'h5a ^ b[7:0], {b[3:0], 8'h35}, 8'h00);
            xfer(1'b0, bdm_pkg::BDM_MODE_BANKED, 8'h35, 12'h0, 8'h00,
                 {b[3:0], 8'h35}, b == 14 ? 8'h00 : 8'h5a ^ b[7:0]);
        end
        $display("test banks done");
        // A bank other than the one last written proves the literal load.
        core_u.load_lit(8'hc3);
        apb(1'b0, 12'h000, 32'h0);
        chk("bank after literal", rd, 32'h00000003);
        xfer(1'b0, bdm_pkg::BDM_MODE_ACCESS, 8'h35, 12'h0, 8'h00,
             12'h035, 8'h5a);
        xfer(1'b1, bdm_pkg::BDM_MODE_ACCESS, 8'h80, 12'h0, 8'h77,
             12'hf80, 8'h00);
        // Offset 0x35 of bank 3 was written in the bank loop.
        xfer(1'b0, bdm_pkg::BDM_MODE_BANKED, 8'h35, 12'h0, 8'h00,
             12'h335, 8'h59);
        xfer(1'b0, bdm_pkg::BDM_MODE_FULL, 8'h35, 12'hf80, 8'h00,
             12'hf80, 8'h77);
        xfer(1'b0, bdm_pkg::BDM_MODE_FULL, 8'h00, 12'he35, 8'h00,
             12'he35, 8'h00);
        xfer(1'b1, bdm_pkg::BDM_MODE_FULL, 8'h00, 12'h335, 8'hc3,
             12'h335, 8'h00);
        xfer(1'b0, bdm_pkg::BDM_MODE_BANKED, 8'h35, 12'h0, 8'h00,
             12'h335, 8'hc3);
        apb(1'b0, 12'h004, 32'h0);
        chk("status addr", rd, 32'h00000335);
        $display("test window and full move done");
        report_and_stop();
    end
endmodule : test_banked_data_memory_addressing
